// ### rtl/tcd_transfer_controller.sv
// two-channel transfer controller moving elements between or within register and ram space, with apb registers
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
module tcd_transfer_controller (
	input  wire logic                  CLK_I,
	input  wire logic                  RESET_N_I,
	input  wire logic                  PSEL_I,
	input  wire logic                  PENABLE_I,
	input  wire logic                  PWRITE_I,
	input  wire logic [7:0]            PADDR_I,
	input  wire logic [31:0]           PWDATA_I,
	output logic [31:0]                PRDATA_O,
	output logic                       PREADY_O,
	output logic                       PSLVERR_O,
	input  wire logic [tcd_pkg::NUM_SRC-2:0] CH0_REQ_I,
	input  wire logic [tcd_pkg::NUM_SRC-2:0] CH1_REQ_I,
	input  wire logic                  CPU_BUSY_I,
	output logic                       BUS_REQ_O,
	output logic                       BUS_WR_O,
	output logic                       BUS_WIDE_O,
	output logic [tcd_pkg::ADDR_W-1:0] BUS_ADDR_O,
	output logic [tcd_pkg::DATA_W-1:0] BUS_WDATA_O,
	input  wire logic [tcd_pkg::DATA_W-1:0] BUS_RDATA_I,
	output logic [tcd_pkg::NUM_CHAN-1:0] DONE_O,
	output logic [tcd_pkg::NUM_CHAN-1:0] ACTIVE_O
);
	import tcd_pkg::*;

	default clocking tcd_cb @(posedge CLK_I);
	endclocking
	default disable iff (!RESET_N_I);

	tcd_mem_if mem ();

	logic [NUM_CHAN-1:0]   enable_reg;
	logic [MODE_W-1:0]     mode_reg [NUM_CHAN];
	logic [CNT_W-1:0]      count_reg [NUM_CHAN];
	logic [ADDR_W-1:0]     srcp_reg [NUM_CHAN];
	logic [ADDR_W-1:0]     dstp_reg [NUM_CHAN];
	logic [CNT_W-1:0]      remain_reg [NUM_CHAN];
	logic [NUM_CHAN-1:0]   active_reg;
	logic [NUM_CHAN-1:0]   pend_reg;
	logic [NUM_CHAN-1:0]   done_reg;
	logic [NUM_CHAN-1:0]   err_reg;
	logic [NUM_CHAN-1:0]   done_pulse_reg;
	logic [NUM_CHAN-1:0]   swtrig;
	logic [NUM_CHAN-1:0]   hw_req;
	logic [NUM_CHAN-1:0]   elem_done;
	logic [NUM_CHAN-1:0]   start;
	logic [NUM_CHAN-1:0]   bad_ptr;
	logic [NUM_SRC-2:0]    req_sync1_reg [NUM_CHAN];
	logic [NUM_SRC-2:0]    req_sync2_reg [NUM_CHAN];
	logic [NUM_SRC-2:0]    req_prev_reg [NUM_CHAN];
	tcd_xfer_t             xf_reg;
	logic                  cur_reg;
	logic [DATA_W-1:0]     data_reg;
	logic                  apb_wr;
	logic                  apb_acc;
	logic                  ch_hit;
	logic                  ch_sel;
	logic [7:0]            ch_ofs;
	logic [31:0]           rdata_next;
	logic                  addr_ok;

	assign apb_acc = PSEL_I && PENABLE_I;
	assign apb_wr = apb_acc && PWRITE_I;
	assign ch_hit = (PADDR_I >= OFS_CH_BASE) &&
		(PADDR_I < 8'(OFS_CH_BASE + 2 * OFS_CH_STEP));
	assign ch_sel = (PADDR_I >= 8'(OFS_CH_BASE + OFS_CH_STEP));
	assign ch_ofs = ch_sel ? 8'(PADDR_I - OFS_CH_BASE - OFS_CH_STEP) :
		8'(PADDR_I - OFS_CH_BASE);
	assign PREADY_O = 1'b1;
	assign PSLVERR_O = apb_acc && !addr_ok;

	function automatic logic in_space(input logic [ADDR_W-1:0] a);
		in_space = ((a >= PFR_BASE) && (a <= PFR_LAST)) ||
			((a >= RAM_BASE) && (a <= RAM_LAST));
	endfunction

	function automatic logic [ADDR_W-1:0] step_ptr(
		input logic [ADDR_W-1:0] p,
		input logic [1:0]        m,
		input logic              wide);
		logic [ADDR_W-1:0] d;
		d = wide ? 16'h0002 : 16'h0001;
		unique case (m)
			PTR_INC: step_ptr = p + d;
			PTR_DEC: step_ptr = p - d;
			default: step_ptr = p;
		endcase
	endfunction

	always_comb begin
		addr_ok = 1'b1;
		rdata_next = 32'h0000_0000;
		if (PADDR_I == OFS_ENABLE) begin
			rdata_next = 32'(enable_reg);
		end else if (PADDR_I == OFS_SWTRIG) begin
			rdata_next = 32'h0000_0000;
		end else if (PADDR_I == OFS_STATUS) begin
			rdata_next = {24'h000000, 2'h0, err_reg, 2'h0, active_reg};
			rdata_next[NUM_CHAN+1:NUM_CHAN] = done_reg;
		end else if (ch_hit && ch_ofs == OFS_MODE) begin
			rdata_next = 32'(mode_reg[ch_sel]);
		end else if (ch_hit && ch_ofs == OFS_COUNT) begin
			rdata_next = active_reg[ch_sel] ? 32'(remain_reg[ch_sel]) :
				32'(count_reg[ch_sel]);
		end else if (ch_hit && ch_ofs == OFS_SRCP) begin
			rdata_next = 32'(srcp_reg[ch_sel]);
		end else if (ch_hit && ch_ofs == OFS_DSTP) begin
			rdata_next = 32'(dstp_reg[ch_sel]);
		end else begin
			addr_ok = 1'b0;
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			PRDATA_O <= 32'h0000_0000;
		end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
			PRDATA_O <= rdata_next;
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			enable_reg <= '0;
		end else if (apb_wr && PADDR_I == OFS_ENABLE) begin
			enable_reg <= PWDATA_I[NUM_CHAN-1:0];
		end
	end

	// write of ones to the trigger word launches channels that are enabled and idle
	assign swtrig = (apb_wr && PADDR_I == OFS_SWTRIG) ?
		PWDATA_I[NUM_CHAN-1:0] : '0;

	assign mem.wide = mode_reg[cur_reg][MODE_SIZE_BIT];
	assign mem.req = (xf_reg != XF_IDLE);
	assign mem.wr = (xf_reg == XF_WRITE);
	assign mem.addr = (xf_reg == XF_WRITE) ? dstp_reg[cur_reg] :
		srcp_reg[cur_reg];
	assign mem.wdata = mem.wide ? data_reg : {8'h00, data_reg[7:0]};

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
			logic [2:0] trig_sel;
			logic [NUM_SRC-2:0] rise;
			assign trig_sel = mode_reg[gi][MODE_TRIG_LSB +: 3];
			assign rise = req_sync2_reg[gi] & ~req_prev_reg[gi];
			assign hw_req[gi] = (trig_sel < SRC_SOFT) && rise[trig_sel];
			assign start[gi] = enable_reg[gi] && !active_reg[gi] &&
				(hw_req[gi] || swtrig[gi]);
			assign elem_done[gi] = (xf_reg == XF_WRITE) && mem.gnt &&
				(cur_reg == 1'(gi));
			assign bad_ptr[gi] = !in_space(srcp_reg[gi]) ||
				!in_space(dstp_reg[gi]);
			assign DONE_O[gi] = done_pulse_reg[gi];
			assign ACTIVE_O[gi] = active_reg[gi];

			always_ff @(posedge CLK_I or negedge RESET_N_I) begin
				if (!RESET_N_I) begin
					req_sync1_reg[gi] <= '0;
					req_sync2_reg[gi] <= '0;
					req_prev_reg[gi] <= '0;
				end else begin
					req_sync1_reg[gi] <= (gi == 0) ? CH0_REQ_I : CH1_REQ_I;
					req_sync2_reg[gi] <= req_sync1_reg[gi];
					req_prev_reg[gi] <= req_sync2_reg[gi];
				end
			end

			always_ff @(posedge CLK_I or negedge RESET_N_I) begin
				if (!RESET_N_I) begin
					mode_reg[gi] <= MODE_RESET;
					count_reg[gi] <= COUNT_RESET;
				end else if (apb_wr && ch_hit && ch_sel == 1'(gi) &&
					!active_reg[gi]) begin
					if (ch_ofs == OFS_MODE)
						mode_reg[gi] <= PWDATA_I[MODE_W-1:0];
					if (ch_ofs == OFS_COUNT) begin
						if (PWDATA_I[CNT_W-1:0] == '0 ||
							PWDATA_I[CNT_W-1:0] > CNT_MAX)
							count_reg[gi] <= CNT_MAX;
						else
							count_reg[gi] <= PWDATA_I[CNT_W-1:0];
					end
				end
			end

			always_ff @(posedge CLK_I or negedge RESET_N_I) begin
				if (!RESET_N_I) begin
					srcp_reg[gi] <= PTR_RESET;
					dstp_reg[gi] <= PTR_RESET;
				end else if (elem_done[gi]) begin
					srcp_reg[gi] <= step_ptr(srcp_reg[gi],
						mode_reg[gi][MODE_SRCM_LSB +: 2],
						mode_reg[gi][MODE_SIZE_BIT]);
					dstp_reg[gi] <= step_ptr(dstp_reg[gi],
						mode_reg[gi][MODE_DSTM_LSB +: 2],
						mode_reg[gi][MODE_SIZE_BIT]);
				end else if (apb_wr && ch_hit && ch_sel == 1'(gi) &&
					!active_reg[gi]) begin
					if (ch_ofs == OFS_SRCP)
						srcp_reg[gi] <= PWDATA_I[ADDR_W-1:0];
					if (ch_ofs == OFS_DSTP)
						dstp_reg[gi] <= PWDATA_I[ADDR_W-1:0];
				end
			end

			always_ff @(posedge CLK_I or negedge RESET_N_I) begin
				if (!RESET_N_I) begin
					active_reg[gi] <= 1'b0;
					remain_reg[gi] <= '0;
					pend_reg[gi] <= 1'b0;
					done_pulse_reg[gi] <= 1'b0;
				end else begin
					done_pulse_reg[gi] <= 1'b0;
					if (start[gi]) begin
						active_reg[gi] <= 1'b1;
						remain_reg[gi] <= count_reg[gi];
						pend_reg[gi] <= 1'b1;
					end else if (active_reg[gi] && !enable_reg[gi] &&
						!pend_reg[gi]) begin
						active_reg[gi] <= 1'b0;
					end else if (elem_done[gi]) begin
						remain_reg[gi] <= 11'(remain_reg[gi] - 1'b1);
						if (remain_reg[gi] == 11'h001) begin
							active_reg[gi] <= 1'b0;
							pend_reg[gi] <= 1'b0;
							done_pulse_reg[gi] <= 1'b1;
						end
					end else if (active_reg[gi] && pend_reg[gi] &&
						xf_reg == XF_IDLE && bad_ptr[gi]) begin
						active_reg[gi] <= 1'b0;
						pend_reg[gi] <= 1'b0;
					end
				end
			end

			// done and error are sticky; a new event wins over the clear
			always_ff @(posedge CLK_I or negedge RESET_N_I) begin
				if (!RESET_N_I) begin
					done_reg[gi] <= 1'b0;
					err_reg[gi] <= 1'b0;
				end else begin
					if (apb_wr && PADDR_I == OFS_STATUS) begin
						if (PWDATA_I[NUM_CHAN + gi])
							done_reg[gi] <= 1'b0;
						if (PWDATA_I[STAT_ERR_LSB + gi])
							err_reg[gi] <= 1'b0;
					end
					if (done_pulse_reg[gi])
						done_reg[gi] <= 1'b1;
					if (active_reg[gi] && pend_reg[gi] &&
						xf_reg == XF_IDLE && bad_ptr[gi])
						err_reg[gi] <= 1'b1;
				end
			end
		end
	endgenerate

	// element mover: read cycle then write cycle, one channel at a time
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			xf_reg <= XF_IDLE;
			cur_reg <= 1'b0;
			data_reg <= '0;
		end else begin
			unique case (xf_reg)
				XF_IDLE: begin
					if (active_reg[0] && !bad_ptr[0]) begin
						cur_reg <= 1'b0;
						xf_reg <= XF_READ;
					end else if (active_reg[1] && !bad_ptr[1]) begin
						cur_reg <= 1'b1;
						xf_reg <= XF_READ;
					end
				end
				XF_READ: begin
					if (mem.gnt) begin
						data_reg <= mem.rdata;
						xf_reg <= XF_WRITE;
					end
				end
				XF_WRITE: begin
					if (mem.gnt) begin
						xf_reg <= XF_IDLE;
					end
				end
			endcase
		end
	end

	tcd_bus_port u_port (
		.mem         (mem),
		.CPU_BUSY_I  (CPU_BUSY_I),
		.BUS_REQ_O   (BUS_REQ_O),
		.BUS_WR_O    (BUS_WR_O),
		.BUS_WIDE_O  (BUS_WIDE_O),
		.BUS_ADDR_O  (BUS_ADDR_O),
		.BUS_WDATA_O (BUS_WDATA_O),
		.BUS_RDATA_I (BUS_RDATA_I)
	);

	AST_RD_THEN_WR: assert property (
		(xf_reg == XF_READ && mem.gnt) |=> xf_reg == XF_WRITE)
		else $error("read not followed by write");
	AST_CPU_STALL: assert property (
		CPU_BUSY_I |-> !BUS_REQ_O)
		else $error("bus taken while cpu busy");
	AST_STALL_HOLD: assert property (
		(mem.req && !mem.gnt) |=> $stable(BUS_ADDR_O))
		else $error("address moved during stall");
	AST_SPACE: assert property (
		BUS_REQ_O |-> in_space(BUS_ADDR_O))
		else $error("access outside register or ram space");
	AST_PRIO: assert property (
		(xf_reg == XF_IDLE && active_reg[0] && !bad_ptr[0])
		|=> cur_reg == 1'b0)
		else $error("channel one served before channel zero");
	AST_DONE_END: assert property (
		DONE_O[0] |-> !active_reg[0] && remain_reg[0] == '0)
		else $error("done before all elements moved");
	AST_COUNT_DEC: assert property (
		(elem_done[1] && !start[1]) |=>
		remain_reg[1] == 11'($past(remain_reg[1]) - 1'b1))
		else $error("remaining count not decremented");
	AST_START_LOAD: assert property (
		start[0] |=> active_reg[0] && remain_reg[0] == $past(count_reg[0]))
		else $error("count not loaded on start");
	AST_GATE: assert property (
		(!enable_reg[0] && !active_reg[0]) |=> !active_reg[0])
		else $error("start while globally disabled");
	AST_INC: assert property (
		(elem_done[0] && mode_reg[0][MODE_SRCM_LSB +: 2] == PTR_INC &&
		!mode_reg[0][MODE_SIZE_BIT]) |=>
		srcp_reg[0] == 16'($past(srcp_reg[0]) + 1'b1))
		else $error("source pointer not incremented");
	AST_CH_SWITCH: assert property (
		(xf_reg == XF_WRITE && mem.gnt) |=> xf_reg == XF_IDLE)
		else $error("element not closed after write");

	COV_DONE0: cover property (DONE_O[0]);
	COV_DONE1: cover property (DONE_O[1]);
	COV_STALL: cover property (mem.req && CPU_BUSY_I);
	COV_BOTH: cover property (active_reg == 2'h3);
endmodule

// ### rtl/tcd_pkg.sv
// package of constants and types for the two-channel transfer controller
package tcd_pkg;
	localparam int NUM_CHAN = 2;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int CNT_W = 11;
	localparam logic [CNT_W-1:0] CNT_MAX = 11'h400;
	localparam int NUM_SRC = 6;
	// request source select codes
	localparam logic [2:0] SRC_SERIAL = 3'h0;
	localparam logic [2:0] SRC_ADC = 3'h1;
	localparam logic [2:0] SRC_TMR16 = 3'h2;
	localparam logic [2:0] SRC_FTMR = 3'h3;
	localparam logic [2:0] SRC_EXT = 3'h4;
	localparam logic [2:0] SRC_SOFT = 3'h5;
	// address space windows
	localparam logic [ADDR_W-1:0] PFR_BASE = 16'hf000;
	localparam logic [ADDR_W-1:0] PFR_LAST = 16'hffff;
	localparam logic [ADDR_W-1:0] RAM_BASE = 16'he000;
	localparam logic [ADDR_W-1:0] RAM_LAST = 16'hefff;
	// apb register byte offsets
	localparam logic [7:0] OFS_ENABLE = 8'h00;
	localparam logic [7:0] OFS_SWTRIG = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_CH_BASE = 8'h10;
	localparam logic [7:0] OFS_CH_STEP = 8'h10;
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_COUNT = 8'h04;
	localparam logic [7:0] OFS_SRCP = 8'h08;
	localparam logic [7:0] OFS_DSTP = 8'h0c;
	// mode register fields
	localparam int MODE_SIZE_BIT = 0;
	localparam int MODE_SRCM_LSB = 1;
	localparam int MODE_DSTM_LSB = 3;
	localparam int MODE_TRIG_LSB = 5;
	localparam int MODE_W = 8;
	localparam logic [1:0] PTR_FIXED = 2'h0;
	localparam logic [1:0] PTR_INC = 2'h1;
	localparam logic [1:0] PTR_DEC = 2'h2;
	localparam logic [MODE_W-1:0] MODE_RESET = 8'h00;
	localparam logic [CNT_W-1:0] COUNT_RESET = 11'h001;
	localparam logic [ADDR_W-1:0] PTR_RESET = 16'h0000;
	localparam int STAT_ERR_LSB = 4;
	typedef enum logic [1:0] {
		XF_IDLE,
		XF_READ,
		XF_WRITE
	} tcd_xfer_t;
endpackage

// ### rtl/tcd_mem_if.sv
// memory access interface between arbiter and mover
`timescale 1ns/1ps
interface tcd_mem_if;
	import tcd_pkg::*;
	logic              req;
	logic              wr;
	logic              wide;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic              gnt;
	modport master (output req, wr, wide, addr, wdata,
		input rdata, gnt);
	modport slave (input req, wr, wide, addr, wdata,
		output rdata, gnt);
endinterface

// ### rtl/tcd_bus_port.sv
// bus port that yields to the cpu and forwards element accesses
`timescale 1ns/1ps
module tcd_bus_port (
	tcd_mem_if.slave                   mem,
	input  wire logic                  CPU_BUSY_I,
	output logic                       BUS_REQ_O,
	output logic                       BUS_WR_O,
	output logic                       BUS_WIDE_O,
	output logic [tcd_pkg::ADDR_W-1:0] BUS_ADDR_O,
	output logic [tcd_pkg::DATA_W-1:0] BUS_WDATA_O,
	input  wire logic [tcd_pkg::DATA_W-1:0] BUS_RDATA_I
);
	import tcd_pkg::*;
	// cpu contention holds the grant off and the mover stalls
	assign mem.gnt = mem.req && !CPU_BUSY_I;
	assign BUS_REQ_O = mem.gnt;
	assign BUS_WR_O = mem.wr;
	assign BUS_WIDE_O = mem.wide;
	assign BUS_ADDR_O = mem.addr;
	assign BUS_WDATA_O = mem.wdata;
	assign mem.rdata = BUS_RDATA_I;
endmodule

// ### bench/tcd_mem_model.sv
// ram and peripheral register model answering the controller's bus port
`timescale 1ns/1ps
module tcd_mem_model (
	input  wire logic        clk_i,
	input  wire logic        req_i,
	input  wire logic        wr_i,
	input  wire logic        wide_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [15:0] wdata_i,
	output logic      [15:0] rdata_o
);
	logic [7:0]  mem [0:8191];
	logic [15:0] last_reg = 16'h0000;
	logic [12:0] a;
	assign a = addr_i[12:0];
	// read data only while a read is performed, otherwise a toggling value
	assign rdata_o = (req_i && !wr_i) ? {mem[a + 13'h1], mem[a]} : ~last_reg;
	always @(posedge clk_i) begin
		last_reg <= rdata_o;
		if (req_i && wr_i) begin
			mem[a] <= wdata_i[7:0];
			if (wide_i)
				mem[a + 13'h1] <= wdata_i[15:8];
		end
	end
	// no coprocessor traffic is ever placed beside the channels
endmodule

// ### bench/test_two_channel_sfr_ram_dma.sv
// self-checking bench for the two-channel transfer controller
`timescale 1ns/1ps
module test_two_channel_sfr_ram_dma;
	import tcd_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [4:0]  ch_req [2] = '{5'h00, 5'h00};
	logic        cpu_busy = 1'b0;
	logic        bus_req;
	logic        bus_wr;
	logic        bus_wide;
	logic [15:0] bus_addr;
	logic [15:0] bus_wdata;
	logic [15:0] bus_rdata;
	logic [1:0]  done;
	logic [1:0]  active;
	logic [31:0] rdat;
	logic        serr;
	logic        stall_en = 1'b0;
	logic        prev_rd = 1'b0;
	logic [15:0] first_addr;
	logic [7:0]  mdl [0:8191];
	int          errors = 0;
	int          total_checks = 0;
	int          seed = 32'h0c4a;
	int          rd_cnt = 0;
	int          wr_cnt = 0;
	int          done_cnt [2] = '{0, 0};

	tcd_transfer_controller u_tcd_transfer_controller (
		.CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .CH0_REQ_I(ch_req[0]), .CH1_REQ_I(ch_req[1]),
		.CPU_BUSY_I(cpu_busy), .BUS_REQ_O(bus_req), .BUS_WR_O(bus_wr),
		.BUS_WIDE_O(bus_wide), .BUS_ADDR_O(bus_addr),
		.BUS_WDATA_O(bus_wdata), .BUS_RDATA_I(bus_rdata),
		.DONE_O(done), .ACTIVE_O(active));
	tcd_mem_model u_tcd_mem_model (
		.clk_i(clk), .req_i(bus_req), .wr_i(bus_wr), .wide_i(bus_wide),
		.addr_i(bus_addr), .wdata_i(bus_wdata), .rdata_o(bus_rdata));

	always #12.5 clk = ~clk;
	always @(posedge clk)
		cpu_busy <= stall_en & 1'($random(seed));

	task automatic chk(input string n, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s expected %0h seen %0h", n, e, g);
		end
	endtask

	task automatic chk_f(input string n, input logic e, g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s expected %b seen %b", n, e, g);
		end
	endtask

	// bus activity monitor
	always @(posedge clk) begin
		if (bus_req) begin
			chk_f("window", 1'b1, bus_addr >= RAM_BASE);
			chk_f("narrow_hi", 1'b1,
				bus_wide || bus_wdata[15:8] == 8'h00);
			if (!bus_wr && rd_cnt == 0)
				first_addr = bus_addr;
			if (bus_wr)
				wr_cnt++;
			else
				rd_cnt++;
		end
		if (prev_rd && !cpu_busy)
			chk_f("write_follows", 1'b1, bus_req && bus_wr);
		chk_f("cpu_first", 1'b0, bus_req && cpu_busy);
		prev_rd = bus_req && !bus_wr;
		for (int c = 0; c < 2; c++)
			if (done[c] === 1'b1)
				done_cnt[c]++;
	end

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// the wait ends when pready is seen high; only the watchdog bounds it
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		chk_f("pready", 1'b1, pready);
		rdat = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	function automatic logic [7:0] cr(input int c, input logic [7:0] o);
		return OFS_CH_BASE + OFS_CH_STEP * 8'(c) + o;
	endfunction

	function automatic int step(input int m, w);
		return m == 1 ? w + 1 : m == 2 ? -(w + 1) : 0;
	endfunction

	// reference copy of one activation on the bench's byte image
	task automatic model(input int sp, dp, sm, dm, w, cnt);
		for (int i = 0; i < cnt; i++) begin
			for (int b = 0; b <= w; b++)
				mdl[(dp + b) & 8191] = mdl[(sp + b) & 8191];
			sp += step(sm, w);
			dp += step(dm, w);
		end
	endtask

	task automatic cmp_mem;
		for (int i = 0; i < 8192; i++)
			chk($sformatf("mem_%0h", i), 32'(mdl[i]),
				32'(u_tcd_mem_model.mem[i]));
	endtask

	task automatic prog(input int c, sm, dm, w, trig, cnt, sp, dp);
		apb(1'b1, cr(c, OFS_MODE), 32'(trig << MODE_TRIG_LSB |
			dm << MODE_DSTM_LSB | sm << MODE_SRCM_LSB | w));
		apb(1'b1, cr(c, OFS_COUNT), 32'(cnt));
		apb(1'b1, cr(c, OFS_SRCP), 32'(sp));
		apb(1'b1, cr(c, OFS_DSTP), 32'(dp));
		model(sp, dp, sm, dm, w, cnt);
		rd_cnt = 0;
		wr_cnt = 0;
	endtask

	task automatic run(input int c, sm, dm, w, trig, cnt, sp, dp);
		int d0;
		int n;
		prog(c, sm, dm, w, trig, cnt, sp, dp);
		d0 = done_cnt[c];
		if (trig == 5) begin
			apb(1'b1, OFS_SWTRIG, 32'(1 << c));
		end else begin
			ch_req[c] <= 5'(1 << trig);
			repeat (4) @(posedge clk);
			ch_req[c] <= 5'h00;
		end
		n = 0;
		while (done_cnt[c] == d0 && n < 8000) begin
			@(posedge clk);
			n++;
		end
		chk("reads", 32'(cnt), 32'(rd_cnt));
		chk("writes", 32'(cnt), 32'(wr_cnt));
		repeat (4) @(posedge clk);
		chk("done_pulses", 32'(d0 + 1), 32'(done_cnt[c]));
		chk_f("active", 1'b0, active[c]);
		cmp_mem;
	endtask

	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		#(25ns * 60000);
		errors++;
		end_of_test;
	end

	initial begin
		int r;
		for (int i = 0; i < 8192; i++) begin
			mdl[i] = 8'($random(seed));
			u_tcd_mem_model.mem[i] = mdl[i];
		end
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		apb(1'b0, cr(0, OFS_MODE), 32'h0);
		chk("mode_rst", 32'(MODE_RESET), rdat);
		apb(1'b0, cr(1, OFS_COUNT), 32'h0);
		chk("count_rst", 32'(COUNT_RESET), rdat);
		apb(1'b0, cr(1, OFS_SRCP), 32'h0);
		chk("ptr_rst", 32'(PTR_RESET), rdat);
		apb(1'b0, 8'hfc, 32'h0);
		chk_f("unmapped", 1'b1, serr);
		// software launch while globally disabled must stay idle
		apb(1'b1, cr(0, OFS_MODE), 32'(SRC_SOFT) << MODE_TRIG_LSB);
		rd_cnt = 0;
		apb(1'b1, OFS_SWTRIG, 32'h1);
		repeat (10) @(posedge clk);
		chk("gated_reads", 32'h0, 32'(rd_cnt));
		apb(1'b1, OFS_ENABLE, 32'h3);
		for (int sm = 0; sm < 4; sm++)
			for (int dm = 0; dm < 4; dm++)
				for (int w = 0; w < 2; w++) begin
					stall_en <= 1'($random(seed));
					r = 2 * (($random(seed) & 63) + 8);
					run((sm + dm) % 2, sm, dm, w, 5, ($random(seed) & 7) + 1,
						(w ? 'hf100 : 'he400) + r,
						(w ? 'he600 : 'hf400) + r);
				end
		for (int k = 0; k < 5; k++)
			run(k % 2, 1, 1, 0, k, 2, 'he800 + 16 * k, 'he900 + 16 * k);
		run(0, 2, 2, 1, 5, 1, 'he802, 'hf802);
		run(1, 1, 0, 0, 5, 1024, 'he000, 'hf000);
		stall_en <= 1'b0;
		prog(1, 1, 1, 1, 5, 2, 'he700, 'hf700);
		prog(0, 1, 1, 1, 5, 2, 'he500, 'hf500);
		r = done_cnt[0] + done_cnt[1];
		apb(1'b1, OFS_SWTRIG, 32'h3);
		repeat (40) @(posedge clk);
		chk("first_src", 32'h0000e500, 32'(first_addr));
		chk("both_done", 32'(r + 2), 32'(done_cnt[0] + done_cnt[1]));
		cmp_mem;
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("done_sticky", 32'h3, 32'(rdat[3:2]));
		prog(0, 1, 1, 0, 5, 4, 'h1000, 'he000);
		apb(1'b1, OFS_SWTRIG, 32'h1);
		repeat (20) @(posedge clk);
		chk("flash_reads", 32'h0, 32'(rd_cnt));
		apb(1'b0, OFS_STATUS, 32'h0);
		chk_f("err_flag", 1'b1, rdat[STAT_ERR_LSB]);
		apb(1'b1, OFS_STATUS, 32'h3c);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("cleared", 32'h0, rdat);
		end_of_test;
	end
endmodule
